// File: src/supply_supervisor_reset_sequencer.sv
// Added by the designer: the register offsets and strobed register access.
`timescale 1ns/1ns
`include "supervisor_defs.svh"
// ----------------------------------------
// ----------------------------------------
module supply_supervisor_reset_sequencer
	import supervisor_pkg::*;
#(
	parameter int unsigned EXT_CYCLES = `POR_EXT_CYCLES
) (
	// clock and reset
	input wire logic core_clk_in,
	input wire logic reset_in,
	// supervisor comparators, high while supply above threshold
	input wire logic core_supply_ok_in,
	input wire logic intf_threshold_adjust_ok_in,
	input wire logic temp_ok_in,
	// host and card pins
	input wire logic session_request_n_in,
	input wire logic card_here_high_in,
	input wire logic card_here_low_in,
	// contact sequencer hooks
	input wire logic deact_done_in,
	output logic activate_out,
	output logic deactivate_out,
	output logic contacts_inactive_out,
	output logic osc_low_freq_out,
	output logic ctrl_reset_out,
	// open-drain status pin
	output logic fault_status_n_out,
	output logic fault_status_n_oe_out,
	// register port
	input wire logic [`ADDR_W-1:0] reg_addr_in,
	input wire logic [31:0] reg_wdata_in,
	input wire logic reg_wr_in,
	input wire logic reg_rd_in,
	output logic [31:0] reg_rdata_out,
	// interrupt
	output logic irq_out
);
	// ----------------------------------------
	// synchronisers
	// ----------------------------------------
	logic [5:0] sync1_r;
	logic [5:0] sync2_r;

	// first stage is read only by the second stage
	// reset loads the idle pin levels so no request or card shows before the pins arrive
	always_ff @(posedge core_clk_in) begin
		if (reset_in) begin
			sync1_r <= `SYNC_IDLE;
			sync2_r <= `SYNC_IDLE;
		end else begin
			sync1_r <= {core_supply_ok_in, intf_threshold_adjust_ok_in, temp_ok_in,
				session_request_n_in, card_here_high_in, card_here_low_in};
			sync2_r <= sync1_r;
		end
	end

	logic core_ok;
	logic intf_ok;
	logic temp_ok;
	logic req_n;
	logic card_present;
	assign core_ok = sync2_r[5];
	assign intf_ok = sync2_r[4];
	assign temp_ok = sync2_r[3];
	assign req_n = sync2_r[2];
	assign card_present = sync2_r[1] || !sync2_r[0];

	// ----------------------------------------
	// reset extension
	// ----------------------------------------
	por_link_if link ();
	assign link.supply_ok = core_ok && intf_ok;

	por_timer #(
		.EXT_CYCLES(EXT_CYCLES)
	) u_timer (
		.core_clk_in(core_clk_in),
		.reset_in(reset_in),
		.link(link)
	);

	// held also keeps the sequencer inactive; a bouncing supply keeps it there
	logic held;
	assign held = link.reset_hold;

	// ----------------------------------------
	// sequencer
	// ----------------------------------------
	seq_state_e state_r;
	seq_state_e state_nxt;

	// next state; commands are looked at only outside the held interval
	always_comb begin
		state_nxt = state_r;
		case (state_r)
			ST_RESET: begin
				if (!held) begin
					state_nxt = ST_INACTIVE;
				end
			end
			ST_INACTIVE: begin
				if (held) begin
					state_nxt = ST_RESET;
				end else if (!req_n && card_present && temp_ok && link.supply_ok) begin
					state_nxt = ST_ACTIVE;
				end
			end
			ST_ACTIVE: begin
				if (!link.supply_ok || !card_present || !temp_ok || req_n) begin
					state_nxt = ST_DEACT;
				end
			end
			ST_DEACT: begin
				if (deact_done_in) begin
					state_nxt = held ? ST_RESET : ST_INACTIVE;
				end
			end
			default: begin
				state_nxt = ST_RESET;
			end
		endcase
	end

	// state register
	always_ff @(posedge core_clk_in) begin
		if (reset_in) begin
			state_r <= ST_RESET;
		end else begin
			state_r <= state_nxt;
		end
	end

	// sequencer outputs from flops
	always_ff @(posedge core_clk_in) begin
		if (reset_in) begin
			activate_out <= 1'b0;
			deactivate_out <= 1'b0;
			contacts_inactive_out <= 1'b1;
			osc_low_freq_out <= 1'b1;
			ctrl_reset_out <= 1'b1;
		end else begin
			activate_out <= (state_nxt == ST_ACTIVE);
			deactivate_out <= (state_nxt == ST_DEACT);
			contacts_inactive_out <= (state_nxt != ST_ACTIVE);
			osc_low_freq_out <= req_n || held;
			ctrl_reset_out <= !link.supply_ok || held;
		end
	end

	// ----------------------------------------
	// status pin
	// ----------------------------------------
	logic status_low_r;

	// low while in reset, on core drop at once, while a session is requested, or no card while idle
	always_ff @(posedge core_clk_in) begin
		if (reset_in) begin
			status_low_r <= 1'b1;
		end else if (!core_ok) begin
			status_low_r <= 1'b1;
		end else if (held) begin
			status_low_r <= 1'b1;
		end else begin
			status_low_r <= !(req_n && card_present);
		end
	end

	// open drain: only ever drives low, pull-up makes the high
	assign fault_status_n_out = 1'b0;
	assign fault_status_n_oe_out = status_low_r;

	// ----------------------------------------
	// interrupts
	// ----------------------------------------
	irq_vec_t irq_stat_r;
	irq_vec_t irq_en_r;
	irq_vec_t events;
	logic core_ok_d_r;

	always_ff @(posedge core_clk_in) begin
		if (reset_in) begin
			core_ok_d_r <= 1'b0;
		end else begin
			core_ok_d_r <= link.supply_ok;
		end
	end

	// one-cycle event strobes; the drop detector starts low so reset gives no false drop
	assign events[`EV_SUPPLY_DROP] = core_ok_d_r && !link.supply_ok;
	assign events[`EV_RESET_DONE] = link.done_pulse;
	assign events[`EV_ACTIVATE] = (state_r == ST_INACTIVE) && (state_nxt == ST_ACTIVE);

	function automatic logic hit(input logic [`ADDR_W-1:0] a, input logic [`ADDR_W-1:0] o);
		hit = (a == o);
	endfunction

	// set wins over a clear in the same cycle
	always_ff @(posedge core_clk_in) begin
		if (reset_in) begin
			irq_stat_r <= '0;
		end else if (reg_wr_in && hit(reg_addr_in, `OFS_IRQ_CLEAR)) begin
			irq_stat_r <= (irq_stat_r & ~reg_wdata_in[`IRQ_W-1:0]) | events;
		end else begin
			irq_stat_r <= irq_stat_r | events;
		end
	end

	// enable register
	always_ff @(posedge core_clk_in) begin
		if (reset_in) begin
			irq_en_r <= `IRQ_EN_RESET;
		end else if (reg_wr_in && hit(reg_addr_in, `OFS_IRQ_ENABLE)) begin
			irq_en_r <= reg_wdata_in[`IRQ_W-1:0];
		end
	end

	assign irq_out = |(irq_stat_r & irq_en_r);

	// ----------------------------------------
	// register read
	// ----------------------------------------
	logic [31:0] status_word;
	// assembled from live state; software sees no snapshot
	always_comb begin
		status_word = 32'h00000000;
		status_word[`ST_RESET_BIT] = held;
		status_word[`ST_SUPPLY_OK_BIT] = link.supply_ok;
		status_word[`ST_CARD_BIT] = card_present;
		status_word[`ST_ACTIVE_BIT] = (state_r == ST_ACTIVE);
		status_word[`ST_DEACT_BIT] = (state_r == ST_DEACT);
		status_word[`ST_OSC_LOW_BIT] = osc_low_freq_out;
	end

	// read data valid the cycle after the strobe; unmapped reads return zero
	always_ff @(posedge core_clk_in) begin
		if (reset_in) begin
			reg_rdata_out <= 32'h00000000;
		end else if (reg_rd_in) begin
			case (reg_addr_in)
				`OFS_STATUS: reg_rdata_out <= status_word;
				`OFS_IRQ_STATUS: reg_rdata_out <= {29'h0, irq_stat_r};
				`OFS_IRQ_ENABLE: reg_rdata_out <= {29'h0, irq_en_r};
				// the clear register has no storage and reads as zero
				default: reg_rdata_out <= 32'h00000000;
			endcase
		end else begin
			reg_rdata_out <= 32'h00000000;
		end
	end

	// ----------------------------------------
	// assertions
	// ----------------------------------------
	sequence s_drop;
		$fell(link.supply_ok) ##0 state_r == ST_ACTIVE;
	endsequence

	// stretch ends while both supplies are still valid
	sequence s_release;
		$fell(held) ##0 link.supply_ok;
	endsequence

	// status release needs an idle host, a card and valid supplies
	sequence s_idle_with_card;
		core_ok && !held && req_n && card_present;
	endsequence

	a_drop_deact: assert property (@(posedge core_clk_in) disable iff (reset_in)
		s_drop |=> deactivate_out)
		else $error("no deactivation after supply drop");
	a_held_inactive: assert property (@(posedge core_clk_in) disable iff (reset_in)
		held |-> state_r != ST_ACTIVE)
		else $error("active while reset held");
	a_contacts_held: assert property (@(posedge core_clk_in) disable iff (reset_in)
		held ##1 held |-> contacts_inactive_out)
		else $error("contacts active during power cycle");
	a_core_drop_status: assert property (@(posedge core_clk_in) disable iff (reset_in)
		!core_ok |=> fault_status_n_oe_out)
		else $error("status not low on core drop");
	a_status_held: assert property (@(posedge core_clk_in) disable iff (reset_in)
		held |=> fault_status_n_oe_out)
		else $error("status released during reset");
	a_osc_low: assert property (@(posedge core_clk_in) disable iff (reset_in)
		req_n |=> osc_low_freq_out)
		else $error("oscillator not low while idle");
	a_merge_reset: assert property (@(posedge core_clk_in) disable iff (reset_in)
		!(core_ok && intf_ok) |=> ctrl_reset_out && held)
		else $error("supply fault did not reset controller");
	a_activate_cond: assert property (@(posedge core_clk_in) disable iff (reset_in)
		$rose(activate_out) |-> $past(card_present) && $past(temp_ok) && $past(!req_n))
		else $error("activation without all conditions");
	a_open_drain: assert property (@(posedge core_clk_in) disable iff (reset_in)
		fault_status_n_out == 1'b0)
		else $error("status pin driven high");
	a_sync_delay: assert property (@(posedge core_clk_in) disable iff (reset_in)
		##2 req_n == $past(session_request_n_in, 2))
		else $error("session input not two-stage synchronised");

	// status pin, reset release, events and oscillator
	a_release_ctrl: assert property (@(posedge core_clk_in) disable iff (reset_in)
		s_release |=> !ctrl_reset_out)
		else $error("controller still in reset after the stretch");
	a_status_release: assert property (@(posedge core_clk_in) disable iff (reset_in)
		s_idle_with_card |=> !fault_status_n_oe_out)
		else $error("status pin not released while idle with card");
	a_no_card_status: assert property (@(posedge core_clk_in) disable iff (reset_in)
		!card_present |=> fault_status_n_oe_out)
		else $error("status pin released with no card");
	a_drop_event: assert property (@(posedge core_clk_in) disable iff (reset_in)
		core_ok_d_r && !link.supply_ok |=> irq_stat_r[`EV_SUPPLY_DROP])
		else $error("supply drop event lost");
	a_osc_leave: assert property (@(posedge core_clk_in) disable iff (reset_in)
		$fell(osc_low_freq_out) |-> $past(!req_n) && $past(!held))
		else $error("oscillator left low mode without a session");

	// sequencer and contacts
	a_req_ignored: assert property (@(posedge core_clk_in) disable iff (reset_in)
		held |=> !activate_out)
		else $error("request taken while reset held");
	a_act_deact_excl: assert property (@(posedge core_clk_in) disable iff (reset_in)
		!(activate_out && deactivate_out))
		else $error("activate and deactivate together");
	a_deact_wait: assert property (@(posedge core_clk_in) disable iff (reset_in)
		state_r == ST_DEACT && !deact_done_in |=> deactivate_out)
		else $error("deactivation dropped before it finished");
	a_deact_done: assert property (@(posedge core_clk_in) disable iff (reset_in)
		state_r == ST_DEACT && deact_done_in && held |=> state_r == ST_RESET
		&& contacts_inactive_out)
		else $error("contacts not held after deactivation in power cycle");
endmodule

// File: src/supervisor_defs.svh
`ifndef SUPERVISOR_DEFS_SVH
`define SUPERVISOR_DEFS_SVH

// ----------------------------------------
// timing
// ----------------------------------------
`define CLK_PERIOD_NS 10
`define POR_EXT_MS 8
`define POR_EXT_CYCLES ((`POR_EXT_MS * 1000000) / `CLK_PERIOD_NS)

// ----------------------------------------
// register map
// ----------------------------------------
`define ADDR_W 4
`define OFS_STATUS 4'h0
`define OFS_IRQ_STATUS 4'h1
`define OFS_IRQ_CLEAR 4'h2
`define OFS_IRQ_ENABLE 4'h3

// ----------------------------------------
// status fields
// ----------------------------------------
`define ST_RESET_BIT 0
`define ST_SUPPLY_OK_BIT 1
`define ST_CARD_BIT 2
`define ST_ACTIVE_BIT 3
`define ST_DEACT_BIT 4
`define ST_OSC_LOW_BIT 5

// ----------------------------------------
// interrupt events
// ----------------------------------------
`define IRQ_W 3
`define EV_SUPPLY_DROP 0
`define EV_RESET_DONE 1
`define EV_ACTIVATE 2
`define IRQ_EN_RESET 3'h0

// ----------------------------------------
// synchroniser idle levels
// ----------------------------------------
// supplies low, temperature bad, no session, card absent
`define SYNC_IDLE 6'h05

`endif

// File: src/supervisor_pkg.sv
`include "supervisor_defs.svh"
package supervisor_pkg;
	typedef enum logic [1:0] {
		ST_RESET,
		ST_INACTIVE,
		ST_ACTIVE,
		ST_DEACT
	} seq_state_e;
	typedef logic [`IRQ_W-1:0] irq_vec_t;
endpackage

// File: src/por_link_if.sv
`timescale 1ns/1ns
// carries the stretched reset between timer and sequencer
interface por_link_if;
	logic supply_ok;
	logic reset_hold;
	logic done_pulse;
	modport timer (input supply_ok, output reset_hold, output done_pulse);
	modport user (output supply_ok, input reset_hold, input done_pulse);
endinterface

// File: src/por_timer.sv
`timescale 1ns/1ns
`include "supervisor_defs.svh"
// stretches reset by the extension interval after the supplies are valid
module por_timer
	import supervisor_pkg::*;
#(
	parameter int unsigned EXT_CYCLES = `POR_EXT_CYCLES
) (
	// clock and reset
	input wire logic core_clk_in,
	input wire logic reset_in,
	// link to sequencer
	por_link_if.timer link
);
	logic [23:0] count_r;
	logic hold_r;

	// any supply drop restarts the count from zero
	always_ff @(posedge core_clk_in) begin
		if (reset_in || !link.supply_ok) begin
			count_r <= 24'h000000;
		end else if (hold_r) begin
			count_r <= count_r + 24'h000001;
		end
	end

	// reset held until the full interval has elapsed with supplies valid
	always_ff @(posedge core_clk_in) begin
		if (reset_in || !link.supply_ok) begin
			hold_r <= 1'b1;
		end else if (count_r == EXT_CYCLES[23:0] - 24'h000001) begin
			hold_r <= 1'b0;
		end
	end

	assign link.reset_hold = hold_r;
	assign link.done_pulse = hold_r && link.supply_ok && !reset_in
		&& (count_r == EXT_CYCLES[23:0] - 24'h000001);

	a_restart_on_drop: assert property (@(posedge core_clk_in) disable iff (reset_in)
		!link.supply_ok |=> hold_r && count_r == 24'h000000)
		else $error("timer not restarted on supply drop");
endmodule

// File: testbench/host_model.sv
`timescale 1ns/1ns
// ----------------------------------------
// host controller side of the session pin
// ----------------------------------------
module host_model (
	// clock
	input wire logic core_clk_in,
	// intent from the test sequence
	input wire logic want_session_in,
	// pin toward the device
	output logic session_request_n_out
);
	// active-low request; the bench keeps want low through reset so the pin idles high
	always_ff @(posedge core_clk_in) begin
		session_request_n_out <= !want_session_in;
	end
endmodule

// File: testbench/tb.sv
`timescale 1ns/1ns
`include "supervisor_defs.svh"
module tb;
	import supervisor_pkg::*;
	localparam int unsigned EXT = 20;
	logic core_clk_in, reset_in, core_ok, intf_ok, temp_ok, want, card_hi, card_lo, ddone;
	logic [3:0] addr;
	logic [31:0] wdata;
	logic wr, rd;
	wire ses_n, act, deact, inact, osc_low, crst, st_n, st_oe, irq;
	wire [31:0] rdata;
	int err_count, checks_done, cnt;
	// pin floats up through the pull-up unless the device sinks it
	wire status_pin = st_oe ? st_n : 1'b1;
	host_model host (.core_clk_in(core_clk_in), .want_session_in(want),
		.session_request_n_out(ses_n));
	supply_supervisor_reset_sequencer #(.EXT_CYCLES(EXT)) dut (.core_clk_in(core_clk_in),
		.reset_in(reset_in), .core_supply_ok_in(core_ok), .intf_threshold_adjust_ok_in(intf_ok),
		.temp_ok_in(temp_ok), .session_request_n_in(ses_n), .card_here_high_in(card_hi),
		.card_here_low_in(card_lo), .deact_done_in(ddone), .activate_out(act),
		.deactivate_out(deact), .contacts_inactive_out(inact), .osc_low_freq_out(osc_low),
		.ctrl_reset_out(crst), .fault_status_n_out(st_n), .fault_status_n_oe_out(st_oe),
		.reg_addr_in(addr), .reg_wdata_in(wdata), .reg_wr_in(wr), .reg_rd_in(rd),
		.reg_rdata_out(rdata), .irq_out(irq));
	// ----------------------------------------
	// helpers
	// ----------------------------------------
	task chk(input logic [31:0] got, input logic [31:0] exp);
		checks_done++;
		if (got !== exp) begin
			err_count++;
			$display("[ERR] t=%0t got=%0h exp=%0h", $time, got, exp);
		end
	endtask
	task results;
		$display("errors=%0d checks=%0d", err_count, checks_done);
		if (err_count == 0 && checks_done > 0) $display("All checks passed");
		else $display("Checks failed");
		$finish;
	endtask
	task cyc(input int n);
		repeat (n) @(posedge core_clk_in);
		#1;
	endtask
	task wr_reg(input logic [3:0] a, input logic [31:0] d);
		@(posedge core_clk_in) begin
			wr <= 1'b1;
			addr <= a;
			wdata <= d;
		end
		@(posedge core_clk_in) wr <= 1'b0;
	endtask
	// read data stands only in the cycle after the strobe
	task rd_chk(input logic [3:0] a, input logic [31:0] exp);
		@(posedge core_clk_in) begin
			rd <= 1'b1;
			addr <= a;
		end
		@(posedge core_clk_in) rd <= 1'b0;
		#1 chk(rdata, exp);
	endtask
	// bounded wait on reset (w=0) or activation (w=1); edges counted in cnt
	task wait_for(input int w, input logic v);
		cnt = 0;
		while (((w == 0) ? crst : act) !== v) begin
			cnt++;
			if (cnt > 300) begin
				err_count++;
				results();
			end
			@(posedge core_clk_in);
			#1;
		end
	endtask
	task power_up;
		@(posedge core_clk_in) begin
			core_ok <= 1'b1;
			intf_ok <= 1'b1;
		end
		wait_for(0, 1'b0);
		chk(cnt >= EXT && cnt <= EXT + 6, 1);
	endtask
	// ----------------------------------------
	// clock and sequence
	// ----------------------------------------
	initial begin
		core_clk_in = 1'b0;
		forever #5 core_clk_in = ~core_clk_in;
	end
	initial begin
		reset_in = 1'b1;
		{core_ok, intf_ok, want, ddone, wr, rd} = 6'h00;
		{temp_ok, card_hi, card_lo} = 3'h7;
		addr = 4'h0;
		wdata = 32'h0;
		err_count = 0;
		checks_done = 0;
		repeat (10) @(posedge core_clk_in);
		reset_in <= 1'b0;
		cyc(1);
		chk({crst, inact, osc_low, status_pin, act}, 5'b11100);
		rd_chk(`OFS_IRQ_ENABLE, 32'h0);
		rd_chk(4'h7, 32'h0);
		rd_chk(`OFS_STATUS, 32'h25);
		// request held during the interval, then a drop restarts the timer
		@(posedge core_clk_in) begin
			core_ok <= 1'b1;
			intf_ok <= 1'b1;
			want <= 1'b1;
		end
		cyc(12);
		chk({crst, act, inact}, 3'b101);
		@(posedge core_clk_in) begin
			intf_ok <= 1'b0;
			want <= 1'b0;
		end
		cyc(4);
		@(posedge core_clk_in) intf_ok <= 1'b1;
		wait_for(0, 1'b0);
		chk(cnt >= EXT && cnt <= EXT + 6, 1);
		// every presence combination with no session requested
		for (int i = 0; i < 4; i++) begin
			@(posedge core_clk_in) begin
				card_hi <= i[0];
				card_lo <= i[1];
			end
			cyc(5);
			chk(status_pin, {31'h0, i[0] | ~i[1]});
		end
		wr_reg(`OFS_IRQ_CLEAR, 32'h7);
		wr_reg(`OFS_IRQ_ENABLE, 32'h1);
		rd_chk(`OFS_IRQ_ENABLE, 32'h1);
		// hot chip refuses the request until it cools
		@(posedge core_clk_in) begin
			temp_ok <= 1'b0;
			want <= 1'b1;
		end
		cyc(10);
		chk(act, 0);
		@(posedge core_clk_in) temp_ok <= 1'b1;
		wait_for(1, 1'b1);
		chk(cnt <= 8, 1);
		chk({osc_low, inact}, 2'b00);
		rd_chk(`OFS_IRQ_STATUS, 32'h4);
		rd_chk(`OFS_STATUS, 32'h0E);
		// drop each supply in turn while a session runs
		for (int s = 0; s < 2; s++) begin
			if (s == 1) begin
				power_up();
				@(posedge core_clk_in) want <= 1'b1;
				wait_for(1, 1'b1);
			end
			@(posedge core_clk_in) begin
				if (s == 0) core_ok <= 1'b0;
				else intf_ok <= 1'b0;
			end
			cyc(5);
			chk({crst, deact, inact, status_pin, irq}, 5'b11101);
			wr_reg(`OFS_IRQ_CLEAR, 32'h7);
			@(posedge core_clk_in) ddone <= 1'b1;
			@(posedge core_clk_in) begin
				ddone <= 1'b0;
				want <= 1'b0;
			end
			cyc(3);
			chk({irq, osc_low}, 2'b01);
		end
		results();
	end
endmodule
